// file: lvr_pkg.sv
// Constants and types shared by the supply monitor and reset-cause recorder
package lvr_pkg;
  // Register byte offsets on the AXI4-Lite bus
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CAUSE = 8'h08;
  localparam logic [7:0] ADDR_EVENT = 8'h0c;
  localparam logic [7:0] ADDR_MASK = 8'h10;
  // Configuration bit positions, all active low
  localparam int CFG_PWR_N = 0;
  localparam int CFG_RST_N = 1;
  localparam int CFG_STOP_N = 2;
  // Configuration reset value: monitor, resets and stop monitoring all enabled
  localparam logic [2:0] CFG_RESET = 3'h0;
  // Status bit position of the under-voltage flag
  localparam int STATUS_FLAG = 0;
  // Reset-cause bit positions
  localparam int CAUSE_POWER_ON = 0;
  localparam int CAUSE_PIN = 1;
  localparam int CAUSE_WATCHDOG = 2;
  localparam int CAUSE_BAD_OPCODE = 3;
  localparam int CAUSE_BAD_FETCH = 4;
  localparam int CAUSE_CHECKER = 5;
  localparam int CAUSE_UNDERVOLT = 6;
  // Reset-cause value after power-on: only the power-on flag
  localparam logic [6:0] CAUSE_RESET = 7'h01;
  // Event bit positions
  localparam int EVT_CAUSE = 0;
  localparam int EVT_PIN_LOW = 1;
  // Consecutive CPU cycles below the falling trip level before a reset
  localparam logic [3:0] FILTER_CYCLES = 4'h9;
  // Crystal cycles below the falling trip level before the flag sets (32..40 window)
  localparam logic [5:0] FLAG_CYCLES = 6'h24;
  // Crystal cycles from pin release to pin sample
  localparam logic [5:0] PIN_SAMPLE_CYCLES = 6'h20;
  // aclk cycles per crystal clock cycle
  localparam logic [3:0] XTAL_DIV = 4'h4;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Pin sampler states
  typedef enum logic [1:0] {PIN_IDLE, PIN_DRIVE, PIN_WAIT} pin_state_t;
endpackage

// file: low_voltage_reset_monitor.sv
// Supply monitor, under-voltage reset filter and reset-cause recorder with AXI4-Lite registers
module low_voltage_reset_monitor (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Analog comparator
  input wire logic below_falling_trip,
  input wire logic above_rising_trip,
  // Power mode from the sequencer
  input wire logic wait_mode,
  input wire logic stop_mode,
  // Reset sources and system reset state
  input wire logic system_reset_active,
  input wire logic watchdog_reset,
  input wire logic bad_opcode_reset,
  input wire logic bad_fetch_reset,
  input wire logic opcode_fetch,
  input wire logic checker_cpu_reset,
  // External active-low reset pin, open drain
  input wire logic reset_pin_i,
  output logic reset_pin_o,
  output logic reset_pin_oe,
  // Under-voltage reset request and interrupt
  output logic undervolt_reset,
  output logic irq
);

  // Whole module state
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic aw_got;
    logic w_got;
    logic [7:0] waddr;
    logic [7:0] wbyte;
    logic wen;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [2:0] cfg;
    logic [3:0] filt_cnt;
    logic uv_reset;
    logic [3:0] xdiv;
    logic [5:0] xcnt;
    logic uv_flag;
    lvr_pkg::pin_state_t pin_st;
    logic [5:0] pin_cnt;
    logic pin_oe;
    logic [6:0] cause;
    logic [1:0] evt;
    logic [1:0] mask;
    logic irq;
  } state_t;

  state_t st; // Registered state
  state_t next_st; // Next state
  logic xtick; // One-cycle crystal clock enable
  logic active; // Monitor currently watching the supply
  logic below; // Qualified below-trip indication
  logic trip; // Filter or stop-mode trip
  logic drive; // Reset pin should be pulled low
  logic [6:0] cause_set; // Cause flags set this cycle
  logic cause_rd; // Cause register read taken this cycle
  logic [1:0] evt_set; // Recorder events raised this cycle
  logic [31:0] rmux; // Read data multiplexer

  // Outputs straight from flops, except reset_pin_o which is tied low
  assign awready = st.awready;
  assign wready = st.wready;
  assign bvalid = st.bvalid;
  assign bresp = st.bresp;
  assign arready = st.arready;
  assign rvalid = st.rvalid;
  assign rdata = st.rdata;
  assign rresp = st.rresp;
  assign reset_pin_o = 1'b0;
  assign reset_pin_oe = st.pin_oe;
  assign undervolt_reset = st.uv_reset;
  assign irq = st.irq;

  // Next-state logic for bus, filter, flag, pin sampler and causes
  always_comb begin
    next_st = st;
    xtick = (st.xdiv == lvr_pkg::XTAL_DIV - 4'h1);
    // Crystal divider
    next_st.xdiv = xtick ? 4'h0 : st.xdiv + 4'h1;

    // Monitor runs when powered; in stop only with stop enable as well
    active = !st.cfg[lvr_pkg::CFG_PWR_N] && (!stop_mode || !st.cfg[lvr_pkg::CFG_STOP_N]);
    below = active && below_falling_trip;

    // Consecutive-cycle filter
    if (!below) begin
      next_st.filt_cnt = 4'h0;
    end else if (st.filt_cnt != lvr_pkg::FILTER_CYCLES) begin
      next_st.filt_cnt = st.filt_cnt + 4'h1;
    end
    // Ninth cycle trips; stop mode bypasses the filter
    trip = below && (stop_mode || (st.filt_cnt >= lvr_pkg::FILTER_CYCLES - 4'h1));

    // Under-voltage reset hold and release
    if (st.uv_reset) begin
      if (above_rising_trip) begin
        next_st.uv_reset = 1'b0;
      end
    end else if (trip && !st.cfg[lvr_pkg::CFG_RST_N]) begin
      next_st.uv_reset = 1'b1;
    end

    // Status flag from crystal-cycle count
    if (system_reset_active || above_rising_trip) begin
      next_st.uv_flag = 1'b0;
      next_st.xcnt = 6'h0;
    end else if (xtick) begin
      if (below) begin
        // Count to the set point inside the allowed window
        if (st.xcnt != lvr_pkg::FLAG_CYCLES) begin
          next_st.xcnt = st.xcnt + 6'h1;
        end
        if (st.xcnt == lvr_pkg::FLAG_CYCLES - 6'h1) begin
          next_st.uv_flag = 1'b1;
        end
      end else begin
        // Between trip levels the flag holds
        next_st.xcnt = 6'h0;
      end
    end

    // Reset pin drive and sampling
    drive = system_reset_active || st.uv_reset;
    next_st.pin_oe = drive;
    cause_set = 7'h0;
    evt_set = 2'h0;
    case (st.pin_st)
      lvr_pkg::PIN_IDLE: begin
        // Low pin while not driven is an external reset
        if (drive) begin
          next_st.pin_st = lvr_pkg::PIN_DRIVE;
        end else if (!reset_pin_i && !st.pin_oe) begin
          cause_set[lvr_pkg::CAUSE_PIN] = 1'b1;
        end
      end
      lvr_pkg::PIN_DRIVE: begin
        // Wait for release
        if (!drive) begin
          next_st.pin_st = lvr_pkg::PIN_WAIT;
          next_st.pin_cnt = 6'h0;
        end
      end
      lvr_pkg::PIN_WAIT: begin
        // Count crystal cycles, then sample once
        if (drive) begin
          next_st.pin_st = lvr_pkg::PIN_DRIVE;
        end else if (xtick) begin
          next_st.pin_cnt = st.pin_cnt + 6'h1;
          if (st.pin_cnt == lvr_pkg::PIN_SAMPLE_CYCLES - 6'h1) begin
            next_st.pin_st = lvr_pkg::PIN_IDLE;
            if (!reset_pin_i) begin
              cause_set[lvr_pkg::CAUSE_PIN] = 1'b1;
              evt_set[lvr_pkg::EVT_PIN_LOW] = 1'b1;
            end
          end
        end
      end
      default: begin
        next_st.pin_st = lvr_pkg::PIN_IDLE;
      end
    endcase

    // Other reset sources
    cause_set[lvr_pkg::CAUSE_WATCHDOG] = watchdog_reset;
    cause_set[lvr_pkg::CAUSE_BAD_OPCODE] = bad_opcode_reset;
    cause_set[lvr_pkg::CAUSE_BAD_FETCH] = bad_fetch_reset && opcode_fetch;
    cause_set[lvr_pkg::CAUSE_CHECKER] = checker_cpu_reset;
    cause_set[lvr_pkg::CAUSE_UNDERVOLT] = next_st.uv_reset && !st.uv_reset;
    // Sticky events, a new event always lands
    evt_set[lvr_pkg::EVT_CAUSE] = |cause_set;
    next_st.evt = st.evt | evt_set;

    // Read channel
    case (araddr)
      lvr_pkg::ADDR_CONFIG: rmux = {29'h0, st.cfg};
      lvr_pkg::ADDR_STATUS: rmux = {31'h0, st.uv_flag};
      lvr_pkg::ADDR_CAUSE: rmux = {25'h0, st.cause};
      lvr_pkg::ADDR_EVENT: rmux = {30'h0, st.evt};
      lvr_pkg::ADDR_MASK: rmux = {30'h0, st.mask};
      default: rmux = 32'h0;
    endcase
    cause_rd = 1'b0;
    if (arvalid && st.arready) begin
      next_st.arready = 1'b0;
      next_st.rvalid = 1'b1;
      next_st.rdata = rmux;
      cause_rd = (araddr == lvr_pkg::ADDR_CAUSE);
      next_st.rresp = (araddr > lvr_pkg::ADDR_MASK || araddr[1:0] != 2'h0) ? lvr_pkg::RESP_SLVERR
                                                                          : lvr_pkg::RESP_OKAY;
    end else if (st.rvalid && rready) begin
      next_st.rvalid = 1'b0;
      next_st.arready = 1'b1;
    end

    // Cause flags: read clears, a set in the same cycle wins
    next_st.cause = (cause_rd ? 7'h0 : st.cause) | cause_set;

    // Write address and data taken in either order
    if (awvalid && st.awready) begin
      next_st.aw_got = 1'b1;
      next_st.awready = 1'b0;
      next_st.waddr = awaddr;
    end
    if (wvalid && st.wready) begin
      next_st.w_got = 1'b1;
      next_st.wready = 1'b0;
      next_st.wbyte = wdata[7:0];
      next_st.wen = wstrb[0];
    end
    // Perform the write once both halves are held
    if (st.aw_got && st.w_got && !st.bvalid) begin
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = lvr_pkg::RESP_OKAY;
      case (st.waddr)
        lvr_pkg::ADDR_CONFIG: begin
          if (st.wen) begin
            next_st.cfg = st.wbyte[2:0];
          end
        end
        lvr_pkg::ADDR_EVENT: begin
          // Write one to clear, a new event wins
          if (st.wen) begin
            next_st.evt = (st.evt & ~st.wbyte[1:0]) | evt_set;
          end
        end
        lvr_pkg::ADDR_MASK: begin
          if (st.wen) begin
            next_st.mask = st.wbyte[1:0];
          end
        end
        lvr_pkg::ADDR_STATUS, lvr_pkg::ADDR_CAUSE: begin
          // Read-only registers ignore writes
          next_st.bresp = lvr_pkg::RESP_OKAY;
        end
        default: begin
          next_st.bresp = lvr_pkg::RESP_SLVERR;
        end
      endcase
    end else if (st.bvalid && bready) begin
      next_st.bvalid = 1'b0;
      next_st.awready = 1'b1;
      next_st.wready = 1'b1;
    end

    // Interrupt only from recorder events, silenced under any reset
    next_st.irq = (|(next_st.evt & next_st.mask)) && !system_reset_active && !st.uv_reset;
  end

  // State register with synchronous reset acting as power-on
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
      st.awready <= 1'b1;
      st.wready <= 1'b1;
      st.arready <= 1'b1;
      st.cfg <= lvr_pkg::CFG_RESET;
      st.cause <= lvr_pkg::CAUSE_RESET;
      st.pin_st <= lvr_pkg::PIN_WAIT;
      st.pin_oe <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Checks on the block's own behaviour
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_filter_nine: assert property (!stop_mode && $rose(st.uv_reset) |-> $past(st.filt_cnt) >= 4'h8)
    else $error("Under-voltage reset before nine below-trip cycles");
  a_uv_release: assert property (st.uv_reset && above_rising_trip |=> !st.uv_reset)
    else $error("Reset not released after rising trip");
  a_pin_low: assert property (st.uv_reset |=> st.pin_oe && !reset_pin_o)
    else $error("Reset pin not driven during under-voltage reset");
  a_cfg_enabled: assert property ($past(!aresetn) |-> st.cfg == 3'h0)
    else $error("Monitor not enabled after reset");
  a_wait_reset: assert property (wait_mode && !stop_mode && st.cfg == 3'h0 && below_falling_trip && st.filt_cnt == 4'h8 |=> st.uv_reset)
    else $error("No under-voltage reset in wait mode");
  a_reset_disable: assert property (st.cfg[1] && !st.uv_reset |=> !st.uv_reset)
    else $error("Reset raised while resets disabled");
  a_stop_off: assert property (stop_mode && st.cfg[2] && !st.uv_reset |=> !st.uv_reset)
    else $error("Monitor active in stop without stop enable");
  a_stop_bypass: assert property (stop_mode && st.cfg == 3'h0 && below_falling_trip |=> st.uv_reset)
    else $error("Stop-mode trip did not bypass filter");
  a_flag_clear: assert property (above_rising_trip |=> !st.uv_flag)
    else $error("Flag set while supply above rising trip");
  a_cause_read: assert property (arvalid && arready && araddr == 8'h08 |=> st.rdata[6:0] == $past(st.cause))
    else $error("Cause read returned wrong value");
  a_irq_reset: assert property (system_reset_active |=> !irq)
    else $error("Interrupt asserted during reset");

endmodule

// file: supply_model.sv
// Comparator and reset sequencer model facing the supply monitor
module supply_model (
  // Clock and supply level: 0 below falling, 1 between, 2 above rising
  input wire logic aclk,
  input wire logic [1:0] level,
  // Reset requests from the monitor and from other sources
  input wire logic undervolt_reset,
  input wire logic hold_reset,
  // Comparator and sequencer outputs
  output logic below_falling_trip,
  output logic above_rising_trip,
  output logic system_reset_active
);
  timeunit 1ns;
  timeprecision 1ps;
  // Comparator outputs follow the supply level at once
  assign below_falling_trip = (level == 2'h0);
  assign above_rising_trip = (level == 2'h2);
  // Sequencer holds the system in reset one cycle behind any request
  always_ff @(posedge aclk) begin
    system_reset_active <= undervolt_reset | hold_reset;
  end
endmodule

// file: low_voltage_reset_monitor_bench.sv
// Self-checking bench for the supply monitor and reset-cause recorder
module low_voltage_reset_monitor_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // Bus signals
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, lvl;
  // Modes, sources, pin and supply
  logic wait_mode, stop_mode, watchdog_reset, bad_opcode_reset, bad_fetch_reset, opcode_fetch, checker_cpu_reset;
  logic hold_reset, ext_low, below, above, sys_rst, pin, reset_pin_o, reset_pin_oe, undervolt_reset, irq;
  // Counters and expectation queues
  int n_errors, compares, seed, cycles, n;
  logic [33:0] bq[$], rq[$];
  // Mode table: config, {wait, stop}, cycles below, reset expected
  logic [2:0] mcfg[4] = '{3'h0, 3'h0, 3'h4, 3'h1};
  logic [1:0] mmode[4] = '{2'h2, 2'h1, 2'h1, 2'h0};
  int mlen[4] = '{14, 4, 20, 20};
  logic mexp[4] = '{1'b1, 1'b1, 1'b0, 1'b0};
  // Open-drain pin with pull-up, also pulled low from outside
  assign pin = (reset_pin_oe ? reset_pin_o : 1'b1) & ~ext_low;
  low_voltage_reset_monitor uut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .below_falling_trip(below), .above_rising_trip(above), .wait_mode, .stop_mode,
    .system_reset_active(sys_rst), .watchdog_reset, .bad_opcode_reset, .bad_fetch_reset, .opcode_fetch,
    .checker_cpu_reset, .reset_pin_i(pin), .reset_pin_o, .reset_pin_oe, .undervolt_reset, .irq);
  supply_model far (.aclk, .level(lvl), .undervolt_reset, .hold_reset,
    .below_falling_trip(below), .above_rising_trip(above), .system_reset_active(sys_rst));
  // Clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // Comparison of one result
  task chk(input logic [33:0] got, input logic [33:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Verdict and end of run
  task test_done;
    $display("Errors: %0d, compares: %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask
  // Bounded wait for the reset request level
  task wait_uv(input logic e, input int m);
    int i;
    for (i = 0; i < m && undervolt_reset !== e; i++) @(posedge aclk);
    chk({33'h0, undervolt_reset}, {33'h0, e});
  endtask
  // Write: address and data together, each released when taken
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    bq.push_back({32'h0, r});
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    @(posedge aclk);
    while (awvalid || wvalid || bready) begin
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bready && bvalid) bready <= 1'b0;
      @(posedge aclk);
    end
  endtask
  // Read: expected response and data noted first
  task rd(input logic [7:0] a, input logic [33:0] e);
    rq.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(posedge aclk);
    while (arvalid || rready) begin
      if (arvalid && arready) arvalid <= 1'b0;
      if (rready && rvalid) rready <= 1'b0;
      @(posedge aclk);
    end
  endtask
  // One-cycle pulse on the reset sources
  task pulse(input logic [3:0] v, input logic f);
    {checker_cpu_reset, bad_fetch_reset, bad_opcode_reset, watchdog_reset} <= v;
    opcode_fetch <= f;
    @(posedge aclk);
    {checker_cpu_reset, bad_fetch_reset, bad_opcode_reset, watchdog_reset} <= 4'h0;
    @(posedge aclk);
  endtask
  // Response watcher takes the oldest note on each answer
  always @(posedge aclk) begin
    if (bvalid === 1'b1 && bready) chk({32'h0, bresp}, bq.pop_front());
    if (rvalid === 1'b1 && rready) chk({rresp, rdata}, rq.pop_front());
  end
  // Hang guard
  always @(posedge aclk) begin
    cycles++;
    if (cycles > 10000) begin
      n_errors++;
      test_done;
    end
  end
  // Main sequence
  initial begin
    seed = 50;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, hold_reset, ext_low} = 8'h0;
    {wait_mode, stop_mode, watchdog_reset, bad_opcode_reset, bad_fetch_reset, opcode_fetch, checker_cpu_reset} = 7'h0;
    {awaddr, araddr, wdata, wstrb, lvl} = {8'h0, 8'h0, 32'h0, 4'h0, 2'h2};
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    cyc(150);
    rd(lvr_pkg::ADDR_CAUSE, 34'h1);
    rd(lvr_pkg::ADDR_CAUSE, 34'h0);
    rd(lvr_pkg::ADDR_CONFIG, 34'h0);
    rd(lvr_pkg::ADDR_STATUS, 34'h0);
    rd(8'h14, {lvr_pkg::RESP_SLVERR, 32'h0});
    wr(8'h14, 32'h0, lvr_pkg::RESP_SLVERR);
    // Random short glitch, then a full trip
    n = 1 + ($random(seed) & 7);
    lvl <= 2'h0;
    cyc(n);
    lvl <= 2'h1;
    cyc(1);
    lvl <= 2'h0;
    cyc(8);
    chk({33'h0, undervolt_reset}, 34'h0);
    wait_uv(1'b1, 6);
    cyc(2);
    chk({33'h0, reset_pin_oe}, 34'h1);
    lvl <= 2'h2;
    wait_uv(1'b0, 4);
    cyc(200);
    rd(lvr_pkg::ADDR_CAUSE, 34'h40);
    // Polling only, all events unmasked
    wr(lvr_pkg::ADDR_EVENT, 32'h3, lvr_pkg::RESP_OKAY);
    wr(lvr_pkg::ADDR_MASK, 32'h3, lvr_pkg::RESP_OKAY);
    wr(lvr_pkg::ADDR_CONFIG, 32'h2, lvr_pkg::RESP_OKAY);
    lvl <= 2'h0;
    cyc(100);
    rd(lvr_pkg::ADDR_STATUS, 34'h0);
    cyc(80);
    rd(lvr_pkg::ADDR_STATUS, 34'h1);
    chk({33'h0, undervolt_reset}, 34'h0);
    chk({33'h0, irq}, 34'h0);
    lvl <= 2'h1;
    cyc(5);
    rd(lvr_pkg::ADDR_STATUS, 34'h1);
    lvl <= 2'h2;
    cyc(3);
    rd(lvr_pkg::ADDR_STATUS, 34'h0);
    wr(lvr_pkg::ADDR_MASK, 32'h0, lvr_pkg::RESP_OKAY);
    // Wait, stop and power settings
    for (int i = 0; i < 4; i++) begin
      wr(lvr_pkg::ADDR_CONFIG, {29'h0, mcfg[i]}, lvr_pkg::RESP_OKAY);
      {wait_mode, stop_mode} <= mmode[i];
      lvl <= 2'h0;
      cyc(mlen[i]);
      chk({33'h0, undervolt_reset}, {33'h0, mexp[i]});
      lvl <= 2'h2;
      {wait_mode, stop_mode} <= 2'h0;
      wait_uv(1'b0, 4);
      cyc(200);
    end
    rd(lvr_pkg::ADDR_CAUSE, 34'h40);
    wr(lvr_pkg::ADDR_CONFIG, 32'h0, lvr_pkg::RESP_OKAY);
    // Each reset source alone, then a data fault
    for (int i = 0; i < 4; i++) begin
      pulse(4'h1 << i, 1'b1);
      rd(lvr_pkg::ADDR_CAUSE, 34'h4 << i);
    end
    pulse(4'h4, 1'b0);
    rd(lvr_pkg::ADDR_CAUSE, 34'h0);
    // Recorder interrupt, and reset above interrupt
    wr(lvr_pkg::ADDR_EVENT, 32'h3, lvr_pkg::RESP_OKAY);
    wr(lvr_pkg::ADDR_MASK, 32'h1, lvr_pkg::RESP_OKAY);
    pulse(4'h1, 1'b1);
    cyc(2);
    chk({33'h0, irq}, 34'h1);
    wr(lvr_pkg::ADDR_EVENT, 32'h1, lvr_pkg::RESP_OKAY);
    cyc(2);
    chk({33'h0, irq}, 34'h0);
    hold_reset <= 1'b1;
    cyc(2);
    pulse(4'h1, 1'b1);
    cyc(2);
    chk({33'h0, irq}, 34'h0);
    hold_reset <= 1'b0;
    cyc(3);
    chk({33'h0, irq}, 34'h1);
    cyc(200);
    rd(lvr_pkg::ADDR_CAUSE, 34'h4);
    // Pin pulled low from outside, then held low past a release
    ext_low <= 1'b1;
    cyc(4);
    ext_low <= 1'b0;
    cyc(2);
    rd(lvr_pkg::ADDR_CAUSE, 34'h2);
    wr(lvr_pkg::ADDR_EVENT, 32'h3, lvr_pkg::RESP_OKAY);
    hold_reset <= 1'b1;
    ext_low <= 1'b1;
    cyc(4);
    hold_reset <= 1'b0;
    cyc(160);
    ext_low <= 1'b0;
    cyc(4);
    rd(lvr_pkg::ADDR_CAUSE, 34'h2);
    rd(lvr_pkg::ADDR_EVENT, 34'h3);
    // Second power-on clears source flags and configuration
    wr(lvr_pkg::ADDR_CONFIG, 32'h7, lvr_pkg::RESP_OKAY);
    pulse(4'h1, 1'b1);
    aresetn <= 1'b0;
    cyc(8);
    aresetn <= 1'b1;
    cyc(150);
    rd(lvr_pkg::ADDR_CAUSE, 34'h1);
    rd(lvr_pkg::ADDR_CONFIG, 34'h0);
    test_done;
  end
endmodule
